// file: rtl/vira_pkg.sv
/*
 * shared constants for the virtual acknowledge / pending-query register block:
 * coprocessor encodings, field layout, special identifier and outcome codes.
 * assumes a single core clock domain shared with the requesting core.
 */
package vira_pkg;

	// ************************************************************
	// coprocessor read encodings
	// ************************************************************
	localparam logic [3:0] COPROC_NUM     = 4'hf;
	localparam logic [2:0] OPC1_VAL       = 3'h0;
	localparam logic [3:0] CRN_VAL        = 4'hc;
	localparam logic [3:0] CRM_PEND1      = 4'hc;
	localparam logic [2:0] OPC2_PEND1     = 3'h2;
	localparam logic [3:0] CRM_ACK0       = 4'h8;
	localparam logic [2:0] OPC2_ACK0      = 3'h0;

	// ************************************************************
	// data layout
	// ************************************************************
	localparam int         DATA_W         = 32;
	localparam int         ID_W           = 24;
	localparam int         ID_NARROW_W    = 16;
	localparam logic [23:0] SPECIAL_ID    = 24'h0003ff;
	localparam logic [31:0] DATA_RESET    = 32'h00000000;
	// id-width field value meaning 24 implemented bits
	localparam logic [2:0] IDW_24BIT      = 3'h1;

	// ************************************************************
	// access outcome
	// ************************************************************
	typedef enum logic [2:0] {
		OUT_NONE,
		OUT_VIRTUAL,
		OUT_PHYSICAL,
		OUT_UNDEF,
		OUT_TRAP_L1,
		OUT_TRAP_L2,
		OUT_TRAP_HYP
	} vira_outcome_t;

	// which register was selected
	typedef enum logic [1:0] {
		SEL_NONE,
		SEL_PEND1,
		SEL_ACK0
	} vira_sel_t;

endpackage : vira_pkg

// file: rtl/vira_id_format.sv
/*
 * formats a raw interrupt identifier into a 32-bit read value.
 * assumes the caller supplies the current id-width setting.
 */
`timescale 1ns/1ps
module vira_id_format (
	// raw identifier and width control
	input  wire logic [23:0] rawId,
	input  wire logic        wide,
	// formatted register word
	output logic      [31:0] word
);

	// upper byte always zero; narrow mode also clears bits 23:16
	always_comb begin
		word = vira_pkg::DATA_RESET;
		word[vira_pkg::ID_NARROW_W-1:0] = rawId[vira_pkg::ID_NARROW_W-1:0];
		if (wide) begin
			word[vira_pkg::ID_W-1:vira_pkg::ID_NARROW_W] =
				rawId[vira_pkg::ID_W-1:vira_pkg::ID_NARROW_W];
		end
	end

endmodule : vira_id_format

// file: rtl/vira_regs.sv
/*
 * virtual group 1 pending-query and virtual group 0 acknowledge registers,
 * reached by coprocessor reads, with routing, undefined and trap checks.
 * assumes the core issues one read request per cycle, synchronous to core_clk,
 * and that arbitration supplies the pending candidate and its signal status.
 */
`timescale 1ns/1ps
module vira_regs (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rstn,
	// coprocessor read request
	input  wire logic        readReq,
	input  wire logic        writeReq,
	input  wire logic [3:0]  coprocNum,
	input  wire logic [2:0]  opc1,
	input  wire logic [3:0]  crn,
	input  wire logic [3:0]  crm,
	input  wire logic [2:0]  opc2,
	input  wire logic        nonSecureLevel1,
	input  wire logic [1:0]  coreInterruptMasks,
	// control bits from the core's system state
	input  wire logic        normalIrqRouteBit,
	input  wire logic        fastIrqRouteBit,
	input  wire logic        sysregEnable32,
	input  wire logic        sysregEnableLevel1,
	input  wire logic        level2Present,
	input  wire logic        level2Is64,
	input  wire logic        hypReg12Trap64,
	input  wire logic        hypReg12Trap32,
	input  wire logic        secureStateBit,
	input  wire logic        trapAllGroup1_32,
	input  wire logic        trapAllGroup1_64,
	input  wire logic        trapAllGroup0_32,
	input  wire logic        trapAllGroup0_64,
	input  wire logic [2:0]  idWidthField,
	// arbitration candidates
	input  wire logic        pend1Valid,
	input  wire logic [23:0] pend1Id,
	input  wire logic        pend0Valid,
	input  wire logic [23:0] pend0Id,
	input  wire logic        pend0Signalable,
	input  wire logic        pend0Ackable,
	// answer to the core
	output logic             readDone,
	output logic [31:0]      readData,
	output logic [2:0]       readOutcome,
	output logic             physPend1Access,
	output logic             physAck0Access,
	// acknowledge to the interrupt state, and the sync hold to the core
	output logic             ackPulse,
	output logic [23:0]      ackId,
	output logic             syncHold
);

	// ************************************************************
	// decode
	// ************************************************************
	vira_pkg::vira_sel_t     sel;
	logic                    commonMatch;
	logic                    isPend1;
	logic                    isAck0;
	logic                    wide;
	vira_pkg::vira_outcome_t outcome;
	logic [23:0]             pend1Raw;
	logic [23:0]             ack0Raw;
	logic [31:0]             pend1Word;
	logic [31:0]             ack0Word;
	logic                    ack0Grant;
	logic                    masked;

	// shared encoding fields, then the two distinct register picks
	assign commonMatch = (coprocNum == vira_pkg::COPROC_NUM) && (opc1 == vira_pkg::OPC1_VAL)
		&& (crn == vira_pkg::CRN_VAL);
	assign isPend1 = commonMatch && (crm == vira_pkg::CRM_PEND1)
		&& (opc2 == vira_pkg::OPC2_PEND1);
	assign isAck0 = commonMatch && (crm == vira_pkg::CRM_ACK0)
		&& (opc2 == vira_pkg::OPC2_ACK0);

	// writes to either encoding are never accepted; no write form exists
	always_comb begin
		sel = vira_pkg::SEL_NONE;
		if (readReq && !writeReq) begin
			if (isPend1) begin
				sel = vira_pkg::SEL_PEND1;
			end else if (isAck0) begin
				sel = vira_pkg::SEL_ACK0;
			end
		end
	end

	// ************************************************************
	// outcome with fixed priority
	// ************************************************************
	// outside non-secure level 1 goes physical first; then undefined beats every trap, then level 1, then hyp/level 2 register traps,
	// then the trap-all bits, then routing
	always_comb begin
		outcome = vira_pkg::OUT_NONE;
		if (sel != vira_pkg::SEL_NONE) begin
			if (!nonSecureLevel1) begin
				outcome = vira_pkg::OUT_PHYSICAL;
			end else if (!sysregEnable32) begin
				outcome = vira_pkg::OUT_UNDEF;
			end else if (!sysregEnableLevel1) begin
				outcome = vira_pkg::OUT_TRAP_L1;
			end else if (level2Present && level2Is64 && hypReg12Trap64) begin
				outcome = vira_pkg::OUT_TRAP_L2;
			end else if (level2Present && !level2Is64 && secureStateBit && hypReg12Trap32) begin
				outcome = vira_pkg::OUT_TRAP_HYP;
			end else if (secureStateBit && (sel == vira_pkg::SEL_PEND1)
				&& (trapAllGroup1_32 || trapAllGroup1_64)) begin
				outcome = vira_pkg::OUT_TRAP_L2;
			end else if (secureStateBit && (sel == vira_pkg::SEL_ACK0)
				&& (trapAllGroup0_32 || trapAllGroup0_64)) begin
				outcome = vira_pkg::OUT_TRAP_L2;
			end else if (sel == vira_pkg::SEL_PEND1) begin
				outcome = normalIrqRouteBit ? vira_pkg::OUT_VIRTUAL
					: vira_pkg::OUT_PHYSICAL;
			end else begin
				outcome = fastIrqRouteBit ? vira_pkg::OUT_VIRTUAL
					: vira_pkg::OUT_PHYSICAL;
			end
		end
	end

	// ************************************************************
	// read values
	// ************************************************************
	assign wide = (idWidthField == vira_pkg::IDW_24BIT);

	// unobservable interrupts show the one special identifier
	assign pend1Raw = pend1Valid ? pend1Id : vira_pkg::SPECIAL_ID;
	assign ack0Grant = pend0Valid && pend0Signalable && pend0Ackable;
	assign ack0Raw = ack0Grant ? pend0Id : vira_pkg::SPECIAL_ID;

	vira_id_format uFmtPend1 (
		.rawId (pend1Raw),
		.wide  (wide),
		.word  (pend1Word)
	);

	vira_id_format uFmtAck0 (
		.rawId (ack0Raw),
		.wide  (wide),
		.word  (ack0Word)
	);

	// ************************************************************
	// answer registers
	// ************************************************************
	// answer stands one cycle after the request
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			readDone        <= 1'b0;
			readData        <= vira_pkg::DATA_RESET;
			readOutcome     <= 3'h0;
			physPend1Access <= 1'b0;
			physAck0Access  <= 1'b0;
		end else begin
			readDone        <= (sel != vira_pkg::SEL_NONE);
			readOutcome     <= outcome;
			physPend1Access <= (outcome == vira_pkg::OUT_PHYSICAL)
				&& (sel == vira_pkg::SEL_PEND1);
			physAck0Access  <= (outcome == vira_pkg::OUT_PHYSICAL)
				&& (sel == vira_pkg::SEL_ACK0);
			if (outcome == vira_pkg::OUT_VIRTUAL) begin
				readData <= (sel == vira_pkg::SEL_ACK0) ? ack0Word : pend1Word;
			end else begin
				readData <= vira_pkg::DATA_RESET;
			end
		end
	end

	// ************************************************************
	// acknowledge side effect
	// ************************************************************
	// only a granted virtual acknowledge activates; pending-query has no effect
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ackPulse <= 1'b0;
			ackId    <= 24'h000000;
		end else begin
			ackPulse <= (outcome == vira_pkg::OUT_VIRTUAL) && (sel == vira_pkg::SEL_ACK0)
				&& ack0Grant;
			ackId    <= ack0Raw;
		end
	end

	// masked virtual acknowledge reads hold the core until activation lands with the answer,
	// so an unmask right after the read cannot see a stale exception signal
	assign masked = (coreInterruptMasks == 2'h0);

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			syncHold <= 1'b0;
		end else begin
			syncHold <= masked && (outcome == vira_pkg::OUT_VIRTUAL)
				&& (sel == vira_pkg::SEL_ACK0);
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	a_pend_no_ack: assert property (@(posedge core_clk) disable iff (!rstn)
		(sel == vira_pkg::SEL_PEND1) |=> !ackPulse)
		else $error("pending-query read caused an acknowledge");

	a_upper_byte_zero: assert property (@(posedge core_clk) disable iff (!rstn)
		readDone |-> (readData[31:24] == 8'h00))
		else $error("upper byte of read data not zero");

	a_narrow_id_clear: assert property (@(posedge core_clk) disable iff (!rstn)
		(readDone && !$past(wide)) |-> (readData[23:16] == 8'h00))
		else $error("narrow id mode left bits 23:16 set");

	a_undef_first: assert property (@(posedge core_clk) disable iff (!rstn)
		((sel != vira_pkg::SEL_NONE) && nonSecureLevel1 && !sysregEnable32)
		|=> (readOutcome == vira_pkg::OUT_UNDEF))
		else $error("undefined access not reported");

	a_trap_level1: assert property (@(posedge core_clk) disable iff (!rstn)
		((sel != vira_pkg::SEL_NONE) && nonSecureLevel1 && sysregEnable32
		&& !sysregEnableLevel1) |=> (readOutcome == vira_pkg::OUT_TRAP_L1))
		else $error("level 1 trap not reported");

	a_ack_special: assert property (@(posedge core_clk) disable iff (!rstn)
		((outcome == vira_pkg::OUT_VIRTUAL) && (sel == vira_pkg::SEL_ACK0) && !ack0Grant)
		|=> (readData[15:0] == 16'h03ff) && !ackPulse)
		else $error("ungranted acknowledge did not return special id");

	a_ack_pulse: assert property (@(posedge core_clk) disable iff (!rstn)
		ackPulse |-> readDone && (readData[15:0] == ackId[15:0]))
		else $error("acknowledge pulse without matching answer");

	a_route_phys: assert property (@(posedge core_clk) disable iff (!rstn)
		((outcome != vira_pkg::OUT_NONE) && (sel == vira_pkg::SEL_PEND1) && nonSecureLevel1
		&& !normalIrqRouteBit && (outcome != vira_pkg::OUT_UNDEF)
		&& (outcome != vira_pkg::OUT_TRAP_L1) && (outcome != vira_pkg::OUT_TRAP_L2)
		&& (outcome != vira_pkg::OUT_TRAP_HYP)) |=> physPend1Access)
		else $error("pending-query not redirected to physical register");

	a_write_refused: assert property (@(posedge core_clk) disable iff (!rstn)
		writeReq |=> !readDone)
		else $error("write form answered");

	a_sync_hold: assert property (@(posedge core_clk) disable iff (!rstn)
		(syncHold) |-> ackPulse || !$past(ack0Grant))
		else $error("masked acknowledge hold without activation");

	a_special_pend: assert property (@(posedge core_clk) disable iff (!rstn)
		((sel == vira_pkg::SEL_PEND1) && (outcome == vira_pkg::OUT_VIRTUAL) && !pend1Valid)
		|=> (readData == {8'h00, vira_pkg::SPECIAL_ID}))
		else $error("unobservable pending interrupt did not return special id");

	a_pend_id_wide: assert property (@(posedge core_clk) disable iff (!rstn)
		((sel == vira_pkg::SEL_PEND1) && (outcome == vira_pkg::OUT_VIRTUAL) && pend1Valid
		&& wide) |=> (readData == {8'h00, $past(pend1Id)}))
		else $error("pending-query id does not match candidate");

	a_ack_id_wide: assert property (@(posedge core_clk) disable iff (!rstn)
		((sel == vira_pkg::SEL_ACK0) && (outcome == vira_pkg::OUT_VIRTUAL) && ack0Grant
		&& wide) |=> (readData == {8'h00, $past(pend0Id)}))
		else $error("acknowledge id does not match granted candidate");

	a_decode_pend: assert property (@(posedge core_clk) disable iff (!rstn)
		(readReq && !writeReq && (coprocNum == 4'hf) && (opc1 == 3'h0) && (crn == 4'hc)
		&& (crm == 4'hc) && (opc2 == 3'h2)) |=> readDone)
		else $error("pending-query encoding not answered");

	a_decode_ack: assert property (@(posedge core_clk) disable iff (!rstn)
		(readReq && !writeReq && (coprocNum == 4'hf) && (opc1 == 3'h0) && (crn == 4'hc)
		&& (crm == 4'h8) && (opc2 == 3'h0)) |=> readDone)
		else $error("acknowledge encoding not answered");

	a_stray_refused: assert property (@(posedge core_clk) disable iff (!rstn)
		(readReq && !isPend1 && !isAck0) |=> !readDone)
		else $error("unknown encoding answered");

	a_done_needs_req: assert property (@(posedge core_clk) disable iff (!rstn)
		readDone |-> ($past(readReq) && !$past(writeReq)))
		else $error("answer without a read request");

	a_virt_pend_route: assert property (@(posedge core_clk) disable iff (!rstn)
		((sel == vira_pkg::SEL_PEND1) && (outcome == vira_pkg::OUT_VIRTUAL))
		|-> (nonSecureLevel1 && normalIrqRouteBit))
		else $error("virtual pending-query reached without normal route bit");

	a_virt_ack_route: assert property (@(posedge core_clk) disable iff (!rstn)
		((sel == vira_pkg::SEL_ACK0) && (outcome == vira_pkg::OUT_VIRTUAL))
		|-> (nonSecureLevel1 && fastIrqRouteBit))
		else $error("virtual acknowledge reached without fast route bit");

	a_phys_ack_route: assert property (@(posedge core_clk) disable iff (!rstn)
		((sel == vira_pkg::SEL_ACK0) && (outcome == vira_pkg::OUT_PHYSICAL))
		|=> (physAck0Access && !physPend1Access))
		else $error("physical acknowledge not flagged");

	a_trap_reg64: assert property (@(posedge core_clk) disable iff (!rstn)
		((sel != vira_pkg::SEL_NONE) && nonSecureLevel1 && sysregEnable32
		&& sysregEnableLevel1 && level2Present && level2Is64 && hypReg12Trap64)
		|=> (readOutcome == vira_pkg::OUT_TRAP_L2))
		else $error("64-bit level 2 register trap not reported");

	a_trap_hyp: assert property (@(posedge core_clk) disable iff (!rstn)
		((sel != vira_pkg::SEL_NONE) && nonSecureLevel1 && sysregEnable32 && sysregEnableLevel1
		&& level2Present && !level2Is64 && secureStateBit && hypReg12Trap32)
		|=> (readOutcome == vira_pkg::OUT_TRAP_HYP))
		else $error("32-bit level 2 register trap not reported");

	a_group1_trap: assert property (@(posedge core_clk) disable iff (!rstn)
		((sel == vira_pkg::SEL_PEND1) && nonSecureLevel1 && secureStateBit
		&& (trapAllGroup1_32 || trapAllGroup1_64))
		|=> (readOutcome inside {vira_pkg::OUT_UNDEF, vira_pkg::OUT_TRAP_L1,
		vira_pkg::OUT_TRAP_L2, vira_pkg::OUT_TRAP_HYP}))
		else $error("trap-all group 1 did not trap the pending-query read");

	a_group0_trap: assert property (@(posedge core_clk) disable iff (!rstn)
		((sel == vira_pkg::SEL_ACK0) && nonSecureLevel1 && secureStateBit
		&& (trapAllGroup0_32 || trapAllGroup0_64))
		|=> (readOutcome inside {vira_pkg::OUT_UNDEF, vira_pkg::OUT_TRAP_L1,
		vira_pkg::OUT_TRAP_L2, vira_pkg::OUT_TRAP_HYP}))
		else $error("trap-all group 0 did not trap the acknowledge read");

	a_one_outcome: assert property (@(posedge core_clk) disable iff (!rstn)
		readDone |-> ((readOutcome != vira_pkg::OUT_NONE)
		&& !(physPend1Access && physAck0Access)))
		else $error("answer without a single outcome");

	a_sync_masked: assert property (@(posedge core_clk) disable iff (!rstn)
		(masked && (sel == vira_pkg::SEL_ACK0) && (outcome == vira_pkg::OUT_VIRTUAL))
		|=> syncHold)
		else $error("masked acknowledge not held for synchronisation");

	a_ack_only_virtual: assert property (@(posedge core_clk) disable iff (!rstn)
		ackPulse |-> (($past(sel) == vira_pkg::SEL_ACK0)
		&& ($past(outcome) == vira_pkg::OUT_VIRTUAL)))
		else $error("acknowledge without a virtual acknowledge read");

endmodule : vira_regs

// file: testbench/vira_core_model.sv
/*
 * core-side model: issues coprocessor reads to the register block.
 * assumes the bench raises issue just after a rising edge of core_clk.
 */
`timescale 1ns/1ps
module vira_core_model (
	// clock and bench control
	input  wire logic       core_clk,
	input  wire logic       issue,
	input  wire logic [1:0] sel,
	input  wire logic       wr,
	// coprocessor request
	output logic            readReq,
	output logic            writeReq,
	output logic [17:0]     enc
);
	logic [17:0] lastEnc = 18'h00000;

	// encoding follows the selector; idle lines show the inverse of the last one
	// so that a stale encoding can never pass for a valid request
	always_comb begin
		readReq = issue & ~wr;
		writeReq = issue & wr;
		case (sel)
			2'h0: enc = {4'hf, 3'h0, 4'hc, 4'hc, 3'h2};
			2'h1: enc = {4'hf, 3'h0, 4'hc, 4'h8, 3'h0};
			default: enc = {4'hf, 3'h0, 4'hc, 4'hc, 3'h0};
		endcase
		if (!issue) begin
			enc = ~lastEnc;
		end
	end

	// remember the last encoding driven
	always @(posedge core_clk) begin
		if (issue) begin
			lastEnc <= enc;
		end
	end
endmodule : vira_core_model

// file: testbench/virtual_irq_ack_pending_regs_bench.sv
/*
 * self-checking bench for vira_regs: a table of reads, then hand cases.
 * assumes vira_pkg and the core model are compiled first.
 */
`timescale 1ns/1ps
module virtual_irq_ack_pending_regs_bench;
	typedef struct packed {
		logic [1:0]  sel;
		logic [13:0] flip;
		logic [2:0]  out;
		logic [31:0] data;
	} vira_row_t;
	localparam logic [2:0]  OV = vira_pkg::OUT_VIRTUAL;
	localparam logic [2:0]  OP = vira_pkg::OUT_PHYSICAL;
	localparam logic [2:0]  OU = vira_pkg::OUT_UNDEF;
	localparam logic [2:0]  O1 = vira_pkg::OUT_TRAP_L1;
	localparam logic [2:0]  O2 = vira_pkg::OUT_TRAP_L2;
	localparam logic [2:0]  OH = vira_pkg::OUT_TRAP_HYP;
	localparam logic [13:0] BASE = 14'h3f90;
	localparam logic [31:0] D1 = 32'h0012abcd;
	localparam logic [31:0] D0 = 32'h0005a5a5;
	logic        core_clk, rstn, issue, wr, readReq, writeReq;
	logic        p1v, p0v, p0s, p0a, readDone, ackPulse, syncHold, physP, physA, ack;
	logic [1:0]  sel, masks;
	logic [2:0]  idW, readOutcome;
	logic [13:0] ctl;
	logic [17:0] enc;
	logic [23:0] ackId;
	logic [31:0] readData;
	int          miscompares = 0;
	int          n_tests = 0;
	vira_row_t   rows [16];

	vira_core_model i_vira_core_model (.core_clk(core_clk), .issue(issue), .sel(sel),
		.wr(wr), .readReq(readReq), .writeReq(writeReq), .enc(enc));
	vira_regs i_vira_regs (.core_clk(core_clk), .rstn(rstn), .readReq(readReq),
		.writeReq(writeReq), .coprocNum(enc[17:14]), .opc1(enc[13:11]), .crn(enc[10:7]),
		.crm(enc[6:3]), .opc2(enc[2:0]), .nonSecureLevel1(ctl[13]),
		.coreInterruptMasks(masks), .normalIrqRouteBit(ctl[12]), .fastIrqRouteBit(ctl[11]),
		.sysregEnable32(ctl[10]), .sysregEnableLevel1(ctl[9]), .level2Present(ctl[8]),
		.level2Is64(ctl[7]), .hypReg12Trap64(ctl[6]), .hypReg12Trap32(ctl[5]),
		.secureStateBit(ctl[4]), .trapAllGroup1_32(ctl[3]), .trapAllGroup1_64(ctl[2]),
		.trapAllGroup0_32(ctl[1]), .trapAllGroup0_64(ctl[0]), .idWidthField(idW),
		.pend1Valid(p1v), .pend1Id(D1[23:0]), .pend0Valid(p0v), .pend0Id(D0[23:0]),
		.pend0Signalable(p0s), .pend0Ackable(p0a), .readDone(readDone),
		.readData(readData), .readOutcome(readOutcome), .physPend1Access(physP),
		.physAck0Access(physA), .ackPulse(ackPulse), .ackId(ackId), .syncHold(syncHold));

	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// answer flags packed so one compare covers them
	function automatic logic [31:0] flg();
		return {24'h0, readDone, readOutcome, ackPulse, syncHold, physP, physA};
	endfunction : flg

	// request held from just after one edge to just after the next
	task automatic rd(input logic [1:0] s, input logic w);
		sel = s;
		wr = w;
		issue = 1'b1;
		@(posedge core_clk);
		#1;
	endtask : rd

	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : wrap_up

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	// watchdog: the whole run needs well under 100 cycles
	initial begin
		#20000;
		miscompares++;
		wrap_up;
	end

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		rows = '{'{2'h0, 14'h0000, OV, D1}, '{2'h1, 14'h0000, OV, D0},
			'{2'h0, 14'h1000, OP, 0}, '{2'h1, 14'h0800, OP, 0},
			'{2'h0, 14'h0400, OU, 0}, '{2'h1, 14'h0200, O1, 0},
			'{2'h0, 14'h0040, O2, 0}, '{2'h1, 14'h00a0, OH, 0},
			'{2'h0, 14'h0008, O2, 0}, '{2'h0, 14'h0004, O2, 0},
			'{2'h1, 14'h0002, O2, 0}, '{2'h1, 14'h0001, O2, 0},
			'{2'h1, 14'h0008, OV, D0}, '{2'h1, 14'h0600, OU, 0},
			'{2'h0, 14'h0018, OV, D1}, '{2'h0, 14'h0140, OV, D1}};
		{rstn, issue, wr, sel, masks, idW, ctl} = {5'h0, 2'h3, 3'h1, BASE};
		{p1v, p0v, p0s, p0a} = 4'hf;
		@(posedge core_clk);
		#1;
		chk(flg() | readData, 32'h0);
		@(posedge core_clk);
		#1;
		rstn = 1'b1;
		$display("reset test done");
		// back-to-back reads, one row per cycle
		foreach (rows[i]) begin
			ctl = BASE ^ rows[i].flip;
			rd(rows[i].sel, 1'b0);
			ack = rows[i].sel == 2'h1 && rows[i].out == OV;
			chk(readData, rows[i].data);
			chk(flg(), {24'h0, 1'b1, rows[i].out, ack, 1'b0,
				rows[i].out == OP && rows[i].sel == 2'h0,
				rows[i].out == OP && rows[i].sel == 2'h1});
			if (ack) begin
				chk({8'h0, ackId}, D0);
			end
		end
		$display("table test done");
		ctl = BASE;
		p1v = 1'b0;
		rd(2'h0, 1'b0);
		chk(readData, 32'h000003ff);
		p1v = 1'b1;
		p0s = 1'b0;
		rd(2'h1, 1'b0);
		chk(readData, 32'h000003ff);
		chk(flg(), {24'h0, 1'b1, OV, 4'h0});
		{p0s, p0a} = 2'h2;
		rd(2'h1, 1'b0);
		chk(readData, 32'h000003ff);
		chk(flg(), {24'h0, 1'b1, OV, 4'h0});
		p0a = 1'b1;
		$display("special id test done");
		idW = 3'h0;
		rd(2'h0, 1'b0);
		chk(readData, 32'h0000abcd);
		rd(2'h1, 1'b0);
		chk(readData, 32'h0000a5a5);
		idW = 3'h1;
		masks = 2'h0;
		rd(2'h1, 1'b0);
		chk(flg(), {24'h0, 1'b1, OV, 4'hc});
		masks = 2'h3;
		// a request from outside non-secure level 1 goes to the physical register
		ctl = BASE ^ 14'h2000;
		rd(2'h0, 1'b0);
		chk(readData, 32'h0);
		chk(flg(), {24'h0, 1'b1, OP, 4'h2});
		ctl = BASE;
		$display("width and sync test done");
		rd(2'h0, 1'b1);
		chk(flg(), 32'h0);
		rd(2'h2, 1'b0);
		chk(flg(), 32'h0);
		issue = 1'b0;
		@(posedge core_clk);
		#1;
		chk(flg(), 32'h0);
		$display("refusal test done");
		// reset in mid-run while an answer stands, then a clean read
		rd(2'h1, 1'b0);
		rstn = 1'b0;
		#1;
		chk(flg() | readData | {8'h0, ackId}, 32'h0);
		issue = 1'b0;
		@(posedge core_clk);
		#1;
		rstn = 1'b1;
		rd(2'h0, 1'b0);
		chk(readData, D1);
		$display("mid-run reset test done");
		wrap_up;
	end
endmodule : virtual_irq_ack_pending_regs_bench
